// ===== hdl/iicm_master.v
/*
 * Single-master two-wire serial engine with an APB register slave.
 * Assumes open-drain pins with external pull-ups, inputs synchronous
 * to pclk, and timer ticks that are one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`include "iicm_defs.vh"

module iicm_master (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire timer2_tick,
    input wire timer3_tick,
    input wire bus_clock_line_in,
    output wire bus_clock_line_out,
    output reg bus_clock_line_oe,
    input wire bus_data_line_in,
    output wire bus_data_line_out,
    output reg bus_data_line_oe,
    input wire alt_data_in,
    output wire transfer_done_irq,
    output wire [1:0] irq_priority_level,
    output wire bus_speed_mode
);

    // ------------------------------------------------------------
    // Engine states.
    // ------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0; // Waiting for a request.
    localparam [2:0] ST_START = 3'h1; // Making a start condition.
    localparam [2:0] ST_BIT = 3'h2; // Moving data bits.
    localparam [2:0] ST_ACK = 3'h3; // Acknowledge slot.
    localparam [2:0] ST_STOP = 3'h4; // Making a stop condition.

    // ------------------------------------------------------------
    // Registers and internal signals.
    // ------------------------------------------------------------
    reg [7:0] serial_mode_0; // Bit count, start, order, edge.
    reg [7:0] serial_mode_1; // Clock master and pin enables.
    reg [7:0] clock_source_select; // Prescaler run and source.
    reg [7:0] bus_control; // Control and status bits.
    reg [7:0] interrupt_control; // Level, enable, request.
    reg [7:0] shift_data; // Transmit and receive shifter.
    reg [2:0] state; // Engine state.
    reg [2:0] phase; // Source tick within one bus bit.
    reg [2:0] bits_left; // Data bits still to move after the current one.
    reg first_done; // A byte has gone since the last stop.
    reg [4:0] prescale; // Dedicated prescaler counter.
    reg scl_seen; // Clock line sampled last cycle.
    reg sda_seen; // Data line sampled last cycle.
    reg scl_prev; // Clock line one cycle earlier.
    reg sda_prev; // Data line one cycle earlier.
    reg [7:0] next_shift; // Shifter after one bit.
    reg src_tick; // One tick of the selected source.
    reg [4:0] div_mask; // Prescaler mask for the chosen divide.

    wire [13:0] reg_index; // Word index from the byte address.
    wire acc; // Access phase of any transfer.
    wire wr_en; // Write takes effect this edge.
    wire hit; // Address names a register.
    wire busy; // Engine or stop request pending.
    wire iic_on; // Two-wire operation selected.
    wire msb_first; // Order bit zero.
    wire rx_mode; // Receive direction.
    wire in_bit; // Data level as the engine sees it.
    wire bit_end; // Last tick of a bus bit.
    wire bus_start; // Start condition seen on the lines.
    wire txbuf_wr; // Write to the transmit buffer.
    wire ctrl_wr; // Write to the control register.
    wire icr_wr; // Write to the interrupt control register.
    wire load_ok; // A byte may be loaded now.
    reg done_evt; // A byte or abort ended this cycle.
    reg mon_evt; // A foreign start was seen during a data bit or ack slot.
    reg ack_cap; // Acknowledge level captured.
    reg ack_val; // The captured level.
    reg stop_done; // Stop condition finished.

    // ------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------
    assign reg_index = paddr[15:2];
    assign acc = psel & penable;
    assign wr_en = acc & pwrite & hit;
    // The slave never inserts wait states.
    assign pready = 1'b1;
    // Unmapped or misaligned accesses answer with an error.
    assign pslverr = acc & ~hit;
    assign hit = (paddr[1:0] == 2'h0) &&
        (reg_index == `IICM_IDX_MODE0 ||
        reg_index == `IICM_IDX_MODE1 ||
        reg_index == `IICM_IDX_CLKSRC ||
        reg_index == `IICM_IDX_TXBUF ||
        reg_index == `IICM_IDX_CTRL ||
        reg_index == `IICM_IDX_ICR);
    assign txbuf_wr = wr_en && reg_index == `IICM_IDX_TXBUF;
    assign ctrl_wr = wr_en && reg_index == `IICM_IDX_CTRL;
    assign icr_wr = wr_en && reg_index == `IICM_IDX_ICR;

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (reg_index)
                `IICM_IDX_MODE0: prdata <= {24'h000000, serial_mode_0};
                `IICM_IDX_MODE1: prdata <= {24'h000000, serial_mode_1};
                `IICM_IDX_CLKSRC: begin
                    prdata <= {24'h000000, clock_source_select};
                end
                // Reading the buffer shows the shifter, so that
                // received data can be fetched.
                `IICM_IDX_TXBUF: prdata <= {24'h000000, shift_data};
                `IICM_IDX_CTRL: begin
                    prdata <= {24'h000000, busy, bus_control[6:0]};
                end
                `IICM_IDX_ICR: begin
                    prdata <= {24'h000000, interrupt_control};
                end
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Plain configuration registers.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_mode_0 <= `IICM_RST_REG;
            serial_mode_1 <= `IICM_RST_REG;
            clock_source_select <= `IICM_RST_REG;
        end else if (wr_en) begin
            // The bit count may be rewritten between bytes.
            if (reg_index == `IICM_IDX_MODE0) begin
                serial_mode_0 <= pwdata[7:0];
            end
            if (reg_index == `IICM_IDX_MODE1) begin
                serial_mode_1 <= pwdata[7:0];
            end
            if (reg_index == `IICM_IDX_CLKSRC) begin
                clock_source_select <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Control register: status bits set by hardware win over
    // a software write in the same cycle.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_control <= `IICM_RST_REG;
        end else begin
            if (ctrl_wr) begin
                bus_control[6:0] <= pwdata[6:0];
            end
            bus_control[7] <= 1'b0;
            // The received acknowledge level is kept here.
            if (ack_cap) begin
                bus_control[`IICM_CT_ACKLV] <= ack_val;
            end
            // A foreign start during a data bit or ack slot sets the monitor flag.
            if (mon_evt) begin
                bus_control[`IICM_CT_MON] <= 1'b1;
            end
            // The stop request clears itself once done.
            if (stop_done) begin
                bus_control[`IICM_CT_STOP] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt control: request set on completion wins over
    // a clear written in the same cycle.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_control <= `IICM_RST_REG;
        end else begin
            if (icr_wr) begin
                interrupt_control <= pwdata[7:0];
            end
            if (done_evt) begin
                interrupt_control[`IICM_IC_IR] <= 1'b1;
            end
        end
    end

    assign transfer_done_irq = interrupt_control[`IICM_IC_IR] &
        interrupt_control[`IICM_IC_IE];
    assign irq_priority_level = interrupt_control[7:6];
    // Zero selects the normal rate; the rate itself comes from
    // the chosen source.
    assign bus_speed_mode = bus_control[`IICM_CT_SPEED];

    // ------------------------------------------------------------
    // Dedicated prescaler, counting only while enabled.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale <= 5'h00;
        end else if (clock_source_select[`IICM_CS_RUN]) begin
            prescale <= prescale + 5'h01;
        end else begin
            prescale <= 5'h00;
        end
    end

    // ------------------------------------------------------------
    // Source tick selection; the fs codes take fs as pclk/2.
    // ------------------------------------------------------------
    always @* begin
        div_mask = 5'h01;
        src_tick = 1'b0;
        case (clock_source_select[2:0])
            3'h0: div_mask = 5'h01;
            3'h1: div_mask = 5'h03;
            3'h2: div_mask = 5'h07;
            `IICM_CS_DIV32: div_mask = 5'h1f;
            3'h4: div_mask = 5'h03;
            3'h5: div_mask = 5'h07;
            default: div_mask = 5'h01;
        endcase
        if (clock_source_select[2:0] == `IICM_CS_TMR2) begin
            src_tick = timer2_tick;
        end else if (clock_source_select[2:0] == `IICM_CS_TMR3) begin
            src_tick = timer3_tick;
        end else begin
            src_tick = clock_source_select[`IICM_CS_RUN] &&
                ((prescale & div_mask) == div_mask);
        end
    end

    // ------------------------------------------------------------
    // Line sampling and start detection.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_seen <= 1'b1;
            sda_seen <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_seen <= bus_clock_line_in;
            // Data comes from the data pin or the alternate input.
            sda_seen <= serial_mode_1[`IICM_M1_INSEL] ?
                bus_data_line_in : alt_data_in;
            scl_prev <= scl_seen;
            sda_prev <= sda_seen;
        end
    end

    // Data input disabled reads as a released line.
    assign in_bit = sda_seen | ~serial_mode_1[`IICM_M1_INEN];
    assign bus_start = scl_seen & scl_prev & sda_prev & ~sda_seen;
    assign iic_on = bus_control[`IICM_CT_PROTO];
    assign msb_first = ~serial_mode_0[`IICM_M0_ORDER];
    assign rx_mode = bus_control[`IICM_CT_DIR];
    assign bit_end = src_tick && phase == `IICM_PH_LAST;
    // Busy covers a running byte and a pending stop.
    assign busy = state != ST_IDLE ||
        bus_control[`IICM_CT_STOP];
    // Loading needs two-wire mode and the internal clock.
    assign load_ok = iic_on & ~busy &
        serial_mode_1[`IICM_M1_MST];

    // ------------------------------------------------------------
    // Shifter step: one bit in, the next bit to the edge.
    // ------------------------------------------------------------
    always @* begin
        if (msb_first) begin
            next_shift = {shift_data[6:0], in_bit};
        end else begin
            next_shift = {in_bit, shift_data[7:1]};
        end
    end

    // ------------------------------------------------------------
    // Engine: eight source ticks per bus bit, clock low for the
    // first four and released for the last four.
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            phase <= 3'h0;
            bits_left <= 3'h0;
            first_done <= 1'b0;
            shift_data <= 8'h00;
            done_evt <= 1'b0;
            mon_evt <= 1'b0;
            ack_cap <= 1'b0;
            ack_val <= 1'b1;
            stop_done <= 1'b0;
        end else begin
            done_evt <= 1'b0;
            mon_evt <= 1'b0;
            ack_cap <= 1'b0;
            stop_done <= 1'b0;
            if (src_tick) begin
                phase <= phase + 3'h1;
            end
            case (state)
                ST_IDLE: begin
                    phase <= 3'h0;
                    if (txbuf_wr && load_ok) begin
                        shift_data <= pwdata[7:0];
                        bits_left <= serial_mode_0[2:0];
                        // The first byte always has a start.
                        if (!first_done ||
                            serial_mode_0[`IICM_M0_STE]) begin
                            state <= ST_START;
                        end else begin
                            state <= ST_BIT;
                        end
                    end else if (bus_control[`IICM_CT_STOP] &&
                        !stop_done) begin
                        // The request bit clears one cycle after the
                        // stop ends, so the pulse blocks a second stop.
                        if (iic_on) begin
                            state <= ST_STOP;
                        end else begin
                            stop_done <= 1'b1;
                        end
                    end
                end
                ST_START: begin
                    if (bit_end) begin
                        state <= ST_BIT;
                    end
                end
                ST_BIT: begin
                    // The shifter moves on the last tick of the bit, so
                    // the data line changes in the same cycle as the clock is pulled low.
                    if (bit_end) begin
                        shift_data <= next_shift;
                    end
                    if (bit_end) begin
                        bits_left <= bits_left - 3'h1;
                        if (bits_left == 3'h0) begin
                            first_done <= 1'b1;
                            if (bus_control[`IICM_CT_ACKEN]) begin
                                state <= ST_ACK;
                            end else begin
                                state <= ST_IDLE;
                                done_evt <= 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    // The slot samples the level, not the shifter.
                    if (src_tick && phase == `IICM_PH_SAMPLE &&
                        !rx_mode) begin
                        ack_cap <= 1'b1;
                        ack_val <= in_bit;
                    end
                    if (bit_end) begin
                        state <= ST_IDLE;
                        done_evt <= 1'b1;
                    end
                end
                ST_STOP: begin
                    if (bit_end) begin
                        state <= ST_IDLE;
                        first_done <= 1'b0;
                        stop_done <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // A foreign start aborts the byte and ends it, unless the buffer is written in the same cycle.
            if (bus_start && (state == ST_BIT || state == ST_ACK) &&
                !txbuf_wr) begin
                state <= ST_IDLE;
                mon_evt <= 1'b1;
                done_evt <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Pin drive: only low or released.
    // ------------------------------------------------------------
    assign bus_clock_line_out = 1'b0;
    assign bus_data_line_out = 1'b0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_clock_line_oe <= 1'b0;
            bus_data_line_oe <= 1'b0;
        end else begin
            case (state)
                ST_START: begin
                    // Both released, the clock low for four ticks first after a byte;
                    // then data falls while the clock is high.
                    bus_clock_line_oe <= phase < `IICM_PH_SCL_HIGH &&
                        first_done;
                    bus_data_line_oe <= phase >= `IICM_PH_SAMPLE;
                end
                ST_BIT: begin
                    bus_clock_line_oe <= phase < `IICM_PH_SCL_HIGH;
                    // Receive releases data; transmit drives zeros.
                    if (msb_first) begin
                        bus_data_line_oe <= !rx_mode && !shift_data[7];
                    end else begin
                        bus_data_line_oe <= !rx_mode && !shift_data[0];
                    end
                end
                ST_ACK: begin
                    bus_clock_line_oe <= phase < `IICM_PH_SCL_HIGH;
                    // Transmit releases data; receive answers.
                    bus_data_line_oe <= rx_mode &&
                        !bus_control[`IICM_CT_ACKLV];
                end
                ST_STOP: begin
                    // Data held low until the clock is high.
                    bus_clock_line_oe <= phase < `IICM_PH_SCL_HIGH;
                    bus_data_line_oe <= phase < `IICM_PH_SAMPLE;
                end
                default: begin
                    // Between bytes the clock is held low.
                    bus_clock_line_oe <= first_done;
                    bus_data_line_oe <= 1'b0;
                end
            endcase
            // Pin function enables gate each line.
            if (!serial_mode_1[`IICM_M1_CLKEN]) begin
                bus_clock_line_oe <= 1'b0;
            end
            if (!serial_mode_1[`IICM_M1_OUTEN]) begin
                bus_data_line_oe <= 1'b0;
            end
        end
    end

endmodule // iicm_master

// ===== shared/iicm_defs.vh
/*
 * Constants of the single-master two-wire engine: register indexes,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef IICM_DEFS_VH
`define IICM_DEFS_VH

// ----------------------------------------------------------------
// Register indexes; the byte address is four times the index.
// ----------------------------------------------------------------
`define IICM_IDX_MODE0 14'h3fa0
`define IICM_IDX_MODE1 14'h3fa1
`define IICM_IDX_CLKSRC 14'h3fa2
`define IICM_IDX_TXBUF 14'h3fa5
`define IICM_IDX_CTRL 14'h3fa6
`define IICM_IDX_ICR 14'h3ff3

// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define IICM_M0_LEN_HI 2
`define IICM_M0_STE 3
`define IICM_M0_ORDER 4
`define IICM_M1_MST 2
`define IICM_M1_OUTEN 4
`define IICM_M1_INEN 5
`define IICM_M1_CLKEN 6
`define IICM_M1_INSEL 7
`define IICM_CS_RUN 3
`define IICM_CT_ACKLV 0
`define IICM_CT_ACKEN 1
`define IICM_CT_PROTO 2
`define IICM_CT_DIR 3
`define IICM_CT_SPEED 4
`define IICM_CT_STOP 5
`define IICM_CT_MON 6
`define IICM_CT_BUSY 7
`define IICM_IC_IR 0
`define IICM_IC_IE 1

// ----------------------------------------------------------------
// Reset values and clock source codes.
// ----------------------------------------------------------------
`define IICM_RST_REG 8'h00
`define IICM_CS_DIV32 3'h3
`define IICM_CS_TMR2 3'h6
`define IICM_CS_TMR3 3'h7

// ----------------------------------------------------------------
// Source ticks per bus bit and phase marks within a bit.
// ----------------------------------------------------------------
`define IICM_TICKS_PER_BIT 4'h8
`define IICM_PH_SCL_HIGH 3'h4
`define IICM_PH_SAMPLE 3'h6
`define IICM_PH_LAST 3'h7

`endif

// ===== tb/iicm_master_props.sv
/* Port checker for iicm_master.
   Assumes a prescaler clock source, so a low clock phase lasts 8+ cycles. */
`timescale 1ns/1ps
module iicm_master_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire bus_clock_line_out,
    input wire bus_clock_line_oe,
    input wire bus_data_line_out,
    input wire transfer_done_irq,
    input wire [1:0] irq_priority_level,
    input wire bus_speed_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // An APB access phase, and whether its address is a register.
    wire in_acc = psel && penable;
    wire mapped = paddr inside {16'hfe80, 16'hfe84, 16'hfe88, 16'hfe94,
        16'hfe98, 16'hffcc};
    property p_ready; in_acc |-> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_slverr; in_acc |-> pslverr == !mapped; endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_clk_out; bus_clock_line_out == 1'b0; endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock high");
    property p_dat_out; bus_data_line_out == 1'b0; endproperty
    a_dat_out: assert property (p_dat_out) else $error("data high");
    property p_clk_low; $rose(bus_clock_line_oe) |-> bus_clock_line_oe[*8];
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("short low");
    property p_irq_fall; $fell(transfer_done_irq) |->
        $past(in_acc && pwrite && paddr == 16'hffcc); endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq lost");
    property p_prio; in_acc && pwrite && paddr == 16'hffcc |=>
        irq_priority_level == $past(pwdata[7:6]); endproperty
    a_prio: assert property (p_prio) else $error("level wrong");
    property p_speed; in_acc && pwrite && paddr == 16'hfe98 |=>
        bus_speed_mode == $past(pwdata[4]); endproperty
    a_speed: assert property (p_speed) else $error("speed wrong");
endmodule // iicm_master_props
bind iicm_master iicm_master_props chk_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .bus_clock_line_out,
    .bus_clock_line_oe, .bus_data_line_out, .transfer_done_irq,
    .irq_priority_level, .bus_speed_mode);

// ===== tb/iicm_slave_model.sv
/* Slave on the two-wire bus: collects bits and pulls data low to ack.
   Assumes open-drain lines resolved by the bench with pull-ups. */
`timescale 1ns/1ps
module iicm_slave_model (
    input wire pclk,
    input wire scl,
    input wire sda,
    output reg pull = 1'b0,
    output reg [7:0] got = 8'h00
);
    reg scl_q;
    reg sda_q;
    reg [3:0] cnt = 4'h0;
    // A start restarts the count; the ninth clock is the ack slot.
    always @(posedge pclk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda_q && !sda) begin
            cnt <= 4'h0;
        end else if (scl && !scl_q) begin
            if (cnt < 4'h8) got <= {got[6:0], sda};
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        end else if (!scl && scl_q) begin
            pull <= (cnt == 4'h8);
        end
    end
endmodule // iicm_slave_model

// ===== tb/iicm_master_test.sv
/* Self-checking bench for iicm_master over APB with a slave model.
   Assumes the checker binds itself from its own file. */
`timescale 1ns/1ps
module iicm_master_test;
    localparam logic [15:0] M0 = 16'hfe80, M1 = 16'hfe84, CS = 16'hfe88;
    localparam logic [15:0] TX = 16'hfe94, CT = 16'hfe98, IC = 16'hffcc;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, c_oe, d_oe, pull, irq, spd;
    logic [1:0] lvl;
    logic [7:0] got;
    int num_errors = 0, checked = 0;
    wire scl = ~c_oe; // Pull-ups give the high level.
    wire sda = ~(d_oe | pull);
    always #4 pclk = ~pclk;
    iicm_master uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .timer2_tick(1'b0),
        .timer3_tick(1'b0), .bus_clock_line_in(scl), .bus_clock_line_out(),
        .bus_clock_line_oe(c_oe), .bus_data_line_in(sda),
        .bus_data_line_out(), .bus_data_line_oe(d_oe), .alt_data_in(1'b0),
        .transfer_done_irq(irq), .irq_priority_level(lvl),
        .bus_speed_mode(spd));
    iicm_slave_model sl (.pclk, .scl, .sda, .pull, .got);
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; waits for pready, releases at once, then waits a cycle.
    task automatic apb(input logic w, input logic [15:0] a,
        input logic [7:0] d);
        int n = 0;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk) penable <= 1'b1;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin num_errors++; results(); end
        {q, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 5000) begin @(posedge pclk); n++; end
        if (n >= 5000) begin num_errors++; results(); end
    endtask
    task automatic t_reset();
        logic [15:0] regs [6] = '{M0, M1, CS, TX, CT, IC};
        foreach (regs[i]) begin
            apb(0, regs[i], 0);
            chk("reset value", 0, q);
        end
        apb(0, 16'hfe00, 0);
        chk("unmapped error", 1, err);
        $display("register reset test done");
    endtask
    task automatic t_first();
        apb(1, CS, 8'h0b);
        apb(1, CT, 8'h06);
        apb(1, M0, 8'h4f);
        apb(1, M1, 8'hf4);
        apb(1, IC, 8'h82);
        chk("speed mode", 0, spd);
        apb(1, TX, 8'ha5);
        apb(0, CT, 0);
        chk("busy control", 32'h86, q);
        wait_irq();
        chk("slave byte", 8'ha5, got);
        apb(0, CT, 0);
        chk("acked control", 32'h06, q);
        chk("irq level", 2'b10, lvl);
        apb(1, IC, 8'h82);
        chk("irq cleared", 0, irq);
        $display("first byte test done");
    endtask
    // Three bits, no start; the slave misses its ack and the slot reads 1.
    task automatic t_second();
        apb(1, M0, 8'h42);
        apb(1, TX, 8'ha0);
        wait_irq();
        chk("short byte", 8'h5b, got);
        apb(0, CT, 0);
        chk("nack control", 32'h07, q);
        apb(1, IC, 8'h82);
        $display("short byte test done");
    endtask
    task automatic t_stop();
        int n = 0;
        apb(1, CT, 8'h26);
        do begin apb(0, CT, 0); n++; end while (q[7] !== 1'b0 && n < 400);
        if (q[7] !== 1'b0) begin num_errors++; results(); end
        // The write above also set the stored ack level back to 0.
        chk("stop control", 32'h06, q);
        chk("idle lines", 2'b11, {scl, sda});
        $display("stop test done");
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_first();
        t_second();
        t_stop();
        results();
    end
endmodule // iicm_master_test
